// >>> hdl/cbps_power_ctrl.sv
// power state, interrupt gating and socket power protection with AXI4-Lite
`include "cbps_regs.svh"
`default_nettype none
module cbps_power_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output var  logic               s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output var  logic               s_axi_wready,
  output var  logic [1:0]         s_axi_bresp,
  output var  logic               s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output var  logic               s_axi_arready,
  output var  logic [31:0]        s_axi_rdata,
  output var  logic [1:0]         s_axi_rresp,
  output var  logic               s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               card_present,
  input  wire logic               card_is_cardbus,
  input  wire cbps_pkg::cbps_vcc_e volt_sense,
  input  wire logic               cb_status_change,
  input  wire logic [3:0]         sixteen_bit_card_status,
  input  wire logic               card_func_irq,
  output var  logic               irq,
  output var  logic               wake_req,
  output var  logic               card_irq_out,
  output var  logic               socket_card_clock_en,
  output var  logic               pci_clk_stop_ok,
  output var  logic               slot_access_en,
  output var  cbps_pkg::cbps_vcc_e vcc_apply
);
  import cbps_pkg::*;
  localparam int NE = `CBPS_NUM_EVT;

  cbps_pstate_e      pstate, next_pstate;
  cbps_vcc_e         vcc_req, next_vcc_req, next_vcc;
  logic              ovr, next_ovr;
  logic [NE-1:0]     evt_en, next_evt_en;
  logic [NE-1:0]     evt_clr, evt_set, evt_stat;
  logic              aw_got, next_aw_got, w_got, next_w_got;
  logic [ADDR_W-1:0] waddr, next_waddr;
  logic [31:0]       wdat, next_wdat;
  logic              wlow, next_wlow, do_wr, wr_open;
  logic              next_awready, next_wready, next_bvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic              next_arready, next_rvalid;
  logic [31:0]       next_rdata;
  logic              present_q, cb_q, blocked_q, blocked, allowed, pending;
  logic [3:0]        st16_q;

  function automatic logic step_ok(cbps_pstate_e f, cbps_pstate_e t);
    unique case (f)
      CBPS_D0, CBPS_D1: step_ok = 1'b1;
      CBPS_D2:          step_ok = (t != CBPS_D1);
      CBPS_D3:          step_ok = (t == CBPS_D0) || (t == CBPS_D3);
    endcase
  endfunction

  function automatic logic mapped(logic [ADDR_W-1:0] a);
    mapped = (a[7:0] <= `CBPS_OFF_LEG_STAT) && (a[1:0] == 2'b00);
  endfunction

  // in D3 only the power state register answers, so software can wake it
  function automatic logic open_at(logic [ADDR_W-1:0] a, cbps_pstate_e s);
    open_at = mapped(a) &&
              ((s != CBPS_D3) || (a[7:0] == `CBPS_OFF_PM));
  endfunction

  // write side: address and data are taken in either order
  always_comb begin
    next_aw_got = aw_got;
    next_w_got  = w_got;
    next_waddr  = waddr;
    next_wdat   = wdat;
    next_wlow   = wlow;
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wdat  = s_axi_wdata;
      next_wlow  = s_axi_wstrb[0];
    end
    do_wr   = aw_got && w_got && !s_axi_bvalid;
    wr_open = do_wr && open_at(waddr, pstate);
    if (do_wr) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = wr_open ? `CBPS_RESP_OKAY : `CBPS_RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
  end

  // register writes; fields only live in byte lane 0
  always_comb begin
    next_pstate = pstate;
    next_vcc_req = vcc_req;
    next_ovr    = ovr;
    next_evt_en = evt_en;
    evt_clr     = '0;
    if (wr_open && wlow) begin
      unique case (waddr[7:0])
        `CBPS_OFF_PM:
          if (step_ok(pstate, cbps_pstate_e'(wdat[1:0])))
            next_pstate = cbps_pstate_e'(wdat[1:0]);
        `CBPS_OFF_EVT_CLR, `CBPS_OFF_LEG_STAT:
          evt_clr = wdat[NE-1:0];
        `CBPS_OFF_EVT_EN:
          next_evt_en = wdat[NE-1:0];
        `CBPS_OFF_LEG_EN:
          next_evt_en = wdat[`CBPS_LEG_EN_LSB +: NE];
        `CBPS_OFF_PWR: begin
          next_vcc_req = cbps_vcc_e'(wdat[`CBPS_PWR_VCC_LSB +: 2]);
          next_ovr     = wdat[`CBPS_PWR_OVR_BIT];
        end
        `CBPS_OFF_LEG_PWR: begin
          next_vcc_req = cbps_vcc_e'(wdat[`CBPS_LPWR_VCC_LSB +: 2]);
          next_ovr     = wdat[`CBPS_LPWR_OVR_BIT];
        end
        default: next_ovr = ovr;
      endcase
    end
  end

  // read side: data is registered at the edge that takes the address
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = '0;
      next_rresp  = `CBPS_RESP_SLVERR;
      if (open_at(s_axi_araddr, pstate)) begin
        next_rresp = `CBPS_RESP_OKAY;
        unique case (s_axi_araddr[7:0])
          `CBPS_OFF_PM:       next_rdata[1:0] = pstate;
          `CBPS_OFF_HDR:      next_rdata[7:0] = `CBPS_HDR_TYPE;
          `CBPS_OFF_EVT,
          `CBPS_OFF_LEG_STAT: next_rdata[NE-1:0] = evt_stat;
          `CBPS_OFF_EVT_EN:   next_rdata[NE-1:0] = evt_en;
          `CBPS_OFF_LEG_EN:
            next_rdata[`CBPS_LEG_EN_LSB +: NE] = evt_en;
          `CBPS_OFF_PWR: begin
            next_rdata[`CBPS_PWR_VCC_LSB +: 2] = vcc_req;
            next_rdata[`CBPS_PWR_OVR_BIT]      = ovr;
          end
          `CBPS_OFF_LEG_PWR: begin
            next_rdata[`CBPS_LPWR_VCC_LSB +: 2] = vcc_req;
            next_rdata[`CBPS_LPWR_OVR_BIT]      = ovr;
          end
          `CBPS_OFF_STATE:
            next_rdata[7:0] = {pstate, vcc_apply, volt_sense,
                               card_is_cardbus, card_present};
          default:            next_rdata = '0;
        endcase
      end
    end
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    next_arready = !next_rvalid;
  end

  // power check; a fault is flagged once each time the request becomes blocked
  always_comb begin
    allowed = card_present && ((vcc_req <= volt_sense) ||
              (ovr && !card_is_cardbus));
    blocked = card_present && (vcc_req != CBPS_VCC_OFF) && !allowed;
    next_vcc = allowed ? vcc_req : CBPS_VCC_OFF;
    evt_set = '0;
    evt_set[`CBPS_EVT_CD] = card_present ^ present_q;
    evt_set[`CBPS_EVT_CB] = cb_status_change & ~cb_q;
    evt_set[`CBPS_EVT_ST16_LSB +: 4] =
      sixteen_bit_card_status & ~st16_q;
    evt_set[`CBPS_EVT_PWR] = blocked & ~blocked_q;
    pending = |(evt_stat & evt_en);
  end

  cbps_evt_latch #(
    .W (NE)
  ) u_evt (
    .clk_sys (clk_sys),
    .rst     (rst),
    .set     (evt_set),
    .clr     (evt_clr),
    .status  (evt_stat)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pstate        <= CBPS_D0;
      vcc_req       <= CBPS_VCC_OFF;
      ovr           <= 1'b0;
      evt_en        <= `CBPS_EVT_EN_RST;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      waddr         <= '0;
      wdat          <= '0;
      wlow          <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CBPS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `CBPS_RESP_OKAY;
      present_q     <= card_present; // no false edge after reset
      cb_q          <= cb_status_change;
      st16_q        <= sixteen_bit_card_status;
      blocked_q     <= 1'b0;
      irq           <= 1'b0;
      wake_req      <= 1'b0;
      card_irq_out  <= 1'b0;
      socket_card_clock_en <= 1'b0;
      pci_clk_stop_ok      <= 1'b0;
      slot_access_en       <= 1'b0;
      vcc_apply     <= CBPS_VCC_OFF;
    end else begin
      pstate        <= next_pstate;
      vcc_req       <= next_vcc_req;
      ovr           <= next_ovr;
      evt_en        <= next_evt_en;
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      waddr         <= next_waddr;
      wdat          <= next_wdat;
      wlow          <= next_wlow;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      present_q     <= card_present;
      cb_q          <= cb_status_change;
      st16_q        <= sixteen_bit_card_status;
      blocked_q     <= blocked;
      // status survives low power; only the output gating changes
      irq           <= pending && (pstate == CBPS_D0);
      wake_req      <= pending && (pstate != CBPS_D0);
      card_irq_out  <= card_func_irq && (pstate == CBPS_D0);
      socket_card_clock_en <= (pstate == CBPS_D0) ||
                              (pstate == CBPS_D1);
      pci_clk_stop_ok <= (pstate == CBPS_D2) || (pstate == CBPS_D3);
      slot_access_en <= (pstate == CBPS_D0) && card_present;
      vcc_apply     <= next_vcc;
    end
  end

  default clocking cb_chk @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_d3_exit;
    (pstate == CBPS_D3) ##1 (pstate != CBPS_D3) |-> pstate == CBPS_D0;
  endproperty
  a_d3_exit: assert property (p_d3_exit)
    else $error("left D3 for a state other than D0");
  property p_d2_no_d1;
    (pstate == CBPS_D2) |=> (pstate != CBPS_D1);
  endproperty
  a_d2_no_d1: assert property (p_d2_no_d1)
    else $error("moved from D2 to D1");
  property p_slot_d0;
    (pstate != CBPS_D0) |=> !slot_access_en;
  endproperty
  a_slot_d0: assert property (p_slot_d0)
    else $error("slot access outside D0");
  property p_cfg_d3;
    (s_axi_arvalid && s_axi_arready && (pstate == CBPS_D3) &&
     (s_axi_araddr[7:0] != `CBPS_OFF_PM))
      |=> s_axi_rvalid && (s_axi_rresp == `CBPS_RESP_SLVERR);
  endproperty
  a_cfg_d3: assert property (p_cfg_d3)
    else $error("register read served in D3");
  property p_wake;
    (pending && (pstate != CBPS_D0)) |=> (wake_req && !irq);
  endproperty
  a_wake: assert property (p_wake)
    else $error("status change not turned into wake");
  property p_func_irq;
    (pstate != CBPS_D0) |=> !card_irq_out;
  endproperty
  a_func_irq: assert property (p_func_irq)
    else $error("card interrupt passed outside D0");
  property p_clk_stop;
    ((pstate == CBPS_D2) || (pstate == CBPS_D3)) |=> !socket_card_clock_en;
  endproperty
  a_clk_stop: assert property (p_clk_stop)
    else $error("socket clock running in D2 or D3");
  property p_hdr;
    (s_axi_arvalid && s_axi_arready && (pstate != CBPS_D3) &&
     (s_axi_araddr[7:0] == `CBPS_OFF_HDR))
      |=> (s_axi_rdata[7:0] == `CBPS_HDR_TYPE);
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("wrong header type");
  property p_mirror;
    (wr_open && wlow && (waddr[7:0] == `CBPS_OFF_LEG_EN))
      |=> (evt_en == $past(wdat[`CBPS_LEG_EN_LSB +: NE]));
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("legacy enable write not reflected");
  property p_no_over;
    (vcc_apply != CBPS_VCC_OFF) |->
      ((vcc_apply <= $past(volt_sense)) ||
       ($past(ovr) && !$past(card_is_cardbus)));
  endproperty
  a_no_over: assert property (p_no_over)
    else $error("voltage above sensed capability applied");
  property p_low_ok;
    (card_present && (vcc_req <= volt_sense)) |=>
      (vcc_apply == $past(vcc_req));
  endproperty
  a_low_ok: assert property (p_low_ok)
    else $error("permitted voltage not applied");
  property p_cb_no_ovr;
    (card_is_cardbus && (vcc_req > volt_sense))
      |=> (vcc_apply == CBPS_VCC_OFF);
  endproperty
  a_cb_no_ovr: assert property (p_cb_no_ovr)
    else $error("override honoured for a CardBus card");
endmodule
`default_nettype wire

// >>> hdl/cbps_regs.svh
// register map, field positions and reset values of the power state block
`ifndef CBPS_REGS_SVH
`define CBPS_REGS_SVH

`define CBPS_OFF_PM        8'h00
`define CBPS_OFF_HDR       8'h04
`define CBPS_OFF_EVT       8'h08
`define CBPS_OFF_EVT_CLR   8'h0C
`define CBPS_OFF_EVT_EN    8'h10
`define CBPS_OFF_LEG_EN    8'h14
`define CBPS_OFF_PWR       8'h18
`define CBPS_OFF_LEG_PWR   8'h1C
`define CBPS_OFF_STATE     8'h20
`define CBPS_OFF_LEG_STAT  8'h24

`define CBPS_HDR_TYPE      8'h82
`define CBPS_NUM_EVT       7
`define CBPS_EVT_CD        0
`define CBPS_EVT_CB        1
`define CBPS_EVT_ST16_LSB  2
`define CBPS_EVT_PWR       6
`define CBPS_EVT_EN_RST    7'h00
`define CBPS_LEG_EN_LSB    1
`define CBPS_PWR_VCC_LSB   0
`define CBPS_PWR_OVR_BIT   4
`define CBPS_LPWR_VCC_LSB  4
`define CBPS_LPWR_OVR_BIT  7
`define CBPS_RESP_OKAY     2'b00
`define CBPS_RESP_SLVERR   2'b10
`endif

// >>> hdl/cbps_pkg.sv
// types shared by the power state block
`default_nettype none
package cbps_pkg;
  typedef enum logic [1:0] {
    CBPS_D0 = 2'b00,
    CBPS_D1 = 2'b01,
    CBPS_D2 = 2'b10,
    CBPS_D3 = 2'b11
  } cbps_pstate_e;
  typedef enum logic [1:0] {
    CBPS_VCC_OFF = 2'b00,
    CBPS_VCC_3V3 = 2'b01,
    CBPS_VCC_5V  = 2'b10,
    CBPS_VCC_RSV = 2'b11
  } cbps_vcc_e;
endpackage
`default_nettype wire

// >>> hdl/cbps_evt_latch.sv
// sticky event status bits with set winning over clear
`default_nettype none
module cbps_evt_latch #(
  parameter int W = 7
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output var  logic [W-1:0] status
);
  logic [W-1:0] next_status;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        next_status[i] = set[i] | (status[i] & ~clr[i]);
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  property p_set_wins;
    @(posedge clk_sys) disable iff (rst)
      (|set) |=> ((status & $past(set)) == $past(set));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against clear");
endmodule
`default_nettype wire

// >>> testbench/cbps_card_model.sv
// card socket model: insertion, card type, voltage sense and event pins
`default_nettype none
module cbps_card_model (
  input  wire logic                clk_sys,
  output var  logic                card_present,
  output var  logic                card_is_cardbus,
  output var  cbps_pkg::cbps_vcc_e volt_sense,
  output var  logic                cb_status_change,
  output var  logic [3:0]          sixteen_bit_card_status,
  output var  logic                card_func_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import cbps_pkg::*;
  initial begin
    card_present = 1'b1;
    card_is_cardbus = 1'b1;
    volt_sense = CBPS_VCC_3V3;
    cb_status_change = 1'b0;
    sixteen_bit_card_status = 4'h0;
    card_func_irq = 1'b1;
  end
  // pins move only just after an edge, like any synchronous source
  task automatic set_card(input logic pres, input logic cb,
                          input cbps_vcc_e vs);
    card_present <= pres;
    card_is_cardbus <= cb;
    volt_sense <= vs;
    @(posedge clk_sys);
  endtask
  // events held two edges so a sampler on either edge sees them
  task automatic pulse(input logic cb, input logic [3:0] st);
    cb_status_change <= cb;
    sixteen_bit_card_status <= st;
    repeat (2) @(posedge clk_sys);
    cb_status_change <= 1'b0;
    sixteen_bit_card_status <= 4'h0;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the power state block
`include "cbps_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cbps_pkg::*;
  localparam logic [1:0] OK = `CBPS_RESP_OKAY;
  localparam logic [1:0] ER = `CBPS_RESP_SLVERR;
  logic clk_sys = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, arready, bvalid, rvalid;
  logic [1:0] bresp, rresp;
  logic pres, cbc, irq, wake, fiq, fiq_o, cclk, pstop, slot, cbst;
  logic [3:0] st16;
  cbps_vcc_e vs, vcc;
  int bad_count = 0, checked = 0, cycles = 0;
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
  always #2.5 clk_sys = ~clk_sys;
  cbps_card_model i_cbps_card_model (.clk_sys(clk_sys), .card_present(pres),
    .card_is_cardbus(cbc), .volt_sense(vs), .cb_status_change(cbst),
    .sixteen_bit_card_status(st16), .card_func_irq(fiq));
  cbps_power_ctrl i_cbps_power_ctrl (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .card_present(pres),
    .card_is_cardbus(cbc), .volt_sense(vs), .cb_status_change(cbst),
    .sixteen_bit_card_status(st16), .card_func_irq(fiq), .irq(irq),
    .wake_req(wake), .card_irq_out(fiq_o), .socket_card_clock_en(cclk),
    .pci_clk_stop_ok(pstop), .slot_access_en(slot), .vcc_apply(vcc));
  task automatic end_of_test();
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a hung handshake is cut here rather than inside every wait loop
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er, input string nm);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    `CHK(nm, {er, ed}, {rresp, rdata})
  endtask
  task automatic t_pm();
    logic [1:0] e;
    for (int s = 0; s < 4; s++)
      for (int t = 0; t < 4; t++)
        if (s != t) begin
          wr(`CBPS_OFF_PM, 32'(s), OK);
          repeat (2) @(posedge clk_sys);
          `CHK("card_clk", s < 2, cclk)
          `CHK("clk_stop", s > 1, pstop)
          `CHK("slot", s == 0, slot)
          `CHK("func_irq", s == 0, fiq_o)
          if (s == 3) begin
            rd(`CBPS_OFF_HDR, 32'h0, ER, "hdr_d3");
            wr(`CBPS_OFF_EVT_EN, 32'h7F, ER);
          end else rd(`CBPS_OFF_HDR, 32'h82, OK, "hdr");
          wr(`CBPS_OFF_PM, 32'(t), OK);
          // illegal moves leave the state where it was
          e = (s < 2 || t == 0 || (s == 2 && t == 3)) ? 2'(t) : 2'(s);
          rd(`CBPS_OFF_PM, {30'h0, e}, OK, "pstate");
          if (e != 2'b00) wr(`CBPS_OFF_PM, 32'h0, OK);
        end
    rd(`CBPS_OFF_EVT_EN, 32'h0, OK, "en_kept");
  endtask
  task automatic t_evt();
    logic p;
    p = 1'b1;
    rd(`CBPS_OFF_EVT, 32'h00, OK, "evt_reset");
    wr(`CBPS_OFF_EVT_CLR, 32'h7F, OK);
    wr(`CBPS_OFF_LEG_EN, 32'hFE, OK);
    rd(`CBPS_OFF_EVT_EN, 32'h7F, OK, "en_mirror");
    for (int s = 0; s < 4; s++) begin
      wr(`CBPS_OFF_PM, 32'(s), OK);
      p = !p;
      i_cbps_card_model.set_card(p, 1'b1, CBPS_VCC_3V3);
      repeat (4) @(posedge clk_sys);
      `CHK("irq", s == 0, irq)
      `CHK("wake", s != 0, wake)
      wr(`CBPS_OFF_PM, 32'h0, OK);
      repeat (2) @(posedge clk_sys);
      `CHK("irq_kept", 1'b1, irq)
      rd(`CBPS_OFF_EVT, 32'h01, OK, "evt_cd");
      wr(`CBPS_OFF_LEG_STAT, 32'h01, OK);
      rd(`CBPS_OFF_EVT, 32'h00, OK, "evt_clr");
    end
    wr(`CBPS_OFF_PM, 32'h2, OK);
    i_cbps_card_model.pulse(1'b1, 4'hF);
    repeat (3) @(posedge clk_sys);
    `CHK("wake_d2", 1'b1, wake)
    wr(`CBPS_OFF_PM, 32'h0, OK);
    rd(`CBPS_OFF_EVT, 32'h3E, OK, "evt_all");
    wr(`CBPS_OFF_EVT_CLR, 32'h3E, OK);
    rd(`CBPS_OFF_EVT, 32'h00, OK, "evt_clr2");
  endtask
  task automatic vchk(input cbps_vcc_e e);
    repeat (2) @(posedge clk_sys);
    `CHK("vcc", e, vcc)
  endtask
  task automatic t_pwr();
    wr(`CBPS_OFF_PWR, 32'h02, OK);
    vchk(CBPS_VCC_OFF);
    rd(`CBPS_OFF_EVT, 32'h40, OK, "pwr_fault");
    wr(`CBPS_OFF_PWR, 32'h12, OK);
    vchk(CBPS_VCC_OFF);
    wr(`CBPS_OFF_PWR, 32'h01, OK);
    vchk(CBPS_VCC_3V3);
    rd(`CBPS_OFF_LEG_PWR, 32'h10, OK, "leg_pwr");
    i_cbps_card_model.set_card(1'b1, 1'b1, CBPS_VCC_5V);
    vchk(CBPS_VCC_3V3);
    i_cbps_card_model.set_card(1'b1, 1'b0, CBPS_VCC_3V3);
    wr(`CBPS_OFF_LEG_PWR, 32'h20, OK);
    vchk(CBPS_VCC_OFF);
    wr(`CBPS_OFF_LEG_PWR, 32'hA0, OK);
    vchk(CBPS_VCC_5V);
    rd(`CBPS_OFF_PWR, 32'h12, OK, "pwr");
    rd(`CBPS_OFF_STATE, 32'h25, OK, "state");
    wr(`CBPS_OFF_EVT_EN, 32'h05, OK);
    rd(`CBPS_OFF_LEG_EN, 32'h0A, OK, "leg_en");
    rd(8'h28, 32'h0, ER, "unmapped");
    wr(8'h06, 32'h1, ER);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_pm();
    t_evt();
    t_pwr();
    end_of_test();
  end
endmodule
`default_nettype wire
